// ---- fms_dev.sv ----
// flash side: mode/status register pair and its logic
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module fms_dev (
   input wire logic clk,             // system clock
   input wire logic rst_b,           // async reset, power-up or device reset
   fms_link_if.dev link,             // command link from the controller
   input wire logic quad_enable,     // quad enable from the other status register
   input wire logic erase_active,    // array erase in progress
   input wire logic program_active,  // array program in progress
   output logic rd_req,              // pulse: array read
   output logic [23:0] rd_addr,      // array read address
   output logic pg_req,              // pulse: array program byte
   output logic [23:0] pg_addr,      // program address
   output logic [7:0] pg_data,       // program data
   output logic term_req,            // pulse: terminate accepted
   output logic [3:0] dummy_clocks,  // dummy clocks for quad reads
   output logic xip_active           // continuous quad read engaged
);
   // ==========================================================
   // decoding helpers
   // dummy code to clock count
   function automatic logic [3:0] dc_clocks(input logic [2:0] code);
      logic [3:0] n;
      n = fms_pkg::DC_CLK_2;
      case (code)
         fms_pkg::DC_CODE_4: n = fms_pkg::DC_CLK_4;
         fms_pkg::DC_CODE_6: n = fms_pkg::DC_CLK_6;
         fms_pkg::DC_CODE_8: n = fms_pkg::DC_CLK_8;
         fms_pkg::DC_CODE_10: n = fms_pkg::DC_CLK_10;
         default: n = fms_pkg::DC_CLK_2;
      endcase
      return n;
   endfunction

   // opcode pair match
   function automatic logic op_is(input logic [7:0] op, input logic [7:0] a,
      input logic [7:0] b);
      return (op == a) || (op == b);
   endfunction

   // ==========================================================
   // state
   logic seq_mode_reg;             // sequential_mode_flag
   logic xip_sel_reg;              // continuous_read_select
   logic [2:0] wrap_reg;           // burst_wrap_mirror
   logic lock_reg;                 // register_lock_flag
   logic [2:0] dc_reg;             // dummy_cycle_count
   logic es_reg;                   // erase_suspended_flag
   logic ps_reg;                   // program_suspended_flag
   logic terminate_enable_reg;                 // terminate_enable
   logic dwa_reg;                  // aligned_address_enable
   logic [23:0] seq_addr_reg;      // next sequential address
   logic xip_reg;                  // continuous read in progress
   logic xip_align_reg;            // continuous read uses aligned form
   fms_pkg::fms_lock_t lk_state_reg; // lock sequence tracker
   logic [7:0] mode_byte;          // assembled mode/quad-read register
   logic [7:0] lock_byte;          // assembled lock/dummy/suspend register
   logic opcode_xfer;              // transfer with an opcode phase
   logic qread_op;                 // quad read opcode seen
   logic [23:0] xip_addr;          // read address after alignment

   assign opcode_xfer = link.req && link.has_op;
   assign qread_op = op_is(link.op, fms_pkg::OP_QREAD, fms_pkg::OP_QREAD_ALIGN);

   // register views, reserved bits zero
   always_comb begin
      mode_byte = 8'h00;
      lock_byte = 8'h00;
      mode_byte[fms_pkg::MODE_SEQ_BIT] = seq_mode_reg;
      mode_byte[fms_pkg::MODE_XIP_BIT] = xip_sel_reg;
      mode_byte[fms_pkg::MODE_WRAP_LO +: 3] = wrap_reg;
      lock_byte[fms_pkg::LK_LOCK_BIT] = lock_reg;
      lock_byte[fms_pkg::LK_DC_LO +: 3] = dc_reg;
      lock_byte[fms_pkg::LK_ES_BIT] = es_reg;
      lock_byte[fms_pkg::LK_PS_BIT] = ps_reg;
      lock_byte[fms_pkg::LK_TERMINATE_ENABLE_BIT] = terminate_enable_reg;
      lock_byte[fms_pkg::LK_DWA_BIT] = dwa_reg;
   end

   // aligned read address
   always_comb begin
      xip_addr = link.addr;
      if (dwa_reg && ((link.has_op && link.op == fms_pkg::OP_QREAD_ALIGN) ||
         (!link.has_op && xip_align_reg))) begin
         xip_addr[1:0] = fms_pkg::ALIGN_ZERO;
      end
   end

   // ==========================================================
   // writable configuration bits
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xip_sel_reg <= 1'b0;
         dc_reg <= fms_pkg::DC_RESET;
         terminate_enable_reg <= 1'b0;
         dwa_reg <= 1'b0;
      end else if (opcode_xfer && !lock_reg) begin
         if (link.op == fms_pkg::OP_WR_MODE) begin
            xip_sel_reg <= link.data[fms_pkg::MODE_XIP_BIT];
         end else if (link.op == fms_pkg::OP_WR_LOCK) begin
            dc_reg <= link.data[fms_pkg::LK_DC_LO +: 3];
            terminate_enable_reg <= link.data[fms_pkg::LK_TERMINATE_ENABLE_BIT];
            dwa_reg <= link.data[fms_pkg::LK_DWA_BIT];
         end
      end
   end

   // burst wrap mirror
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrap_reg <= fms_pkg::WRAP_RESET;
      end else if (opcode_xfer && link.op == fms_pkg::OP_SET_WRAP) begin
         wrap_reg <= link.data[fms_pkg::WRAP_SRC_LO +: 3];
      end
   end

   // suspend flags
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         es_reg <= 1'b0;
         ps_reg <= 1'b0;
      end else if (opcode_xfer && op_is(link.op, fms_pkg::OP_SUSP_A, fms_pkg::OP_SUSP_B)) begin
         if (erase_active) begin
            es_reg <= 1'b1;
         end else if (program_active) begin
            ps_reg <= 1'b1;
         end
      end else if (opcode_xfer && op_is(link.op, fms_pkg::OP_RES_A, fms_pkg::OP_RES_B)) begin
         // resume clears both
         es_reg <= 1'b0;
         ps_reg <= 1'b0;
      end
   end

   // lock sequence: opcode then two verification bytes back to back
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lk_state_reg <= fms_pkg::LK_IDLE;
         lock_reg <= 1'b0;
      end else if (link.req) begin
         case (lk_state_reg)
            fms_pkg::LK_GOT_OP: begin
               lk_state_reg <= (link.has_op && link.op == fms_pkg::LOCK_VER1) ?
                  fms_pkg::LK_GOT_V1 : fms_pkg::LK_IDLE;
            end
            fms_pkg::LK_GOT_V1: begin
               lk_state_reg <= fms_pkg::LK_IDLE;
               if (link.has_op && link.op == fms_pkg::LOCK_VER2) begin
                  lock_reg <= 1'b1;
               end
            end
            default: begin
               lk_state_reg <= (link.has_op && link.op == fms_pkg::OP_LOCK) ?
                  fms_pkg::LK_GOT_OP : fms_pkg::LK_IDLE;
            end
         endcase
      end
   end

   // sequential program mode
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_mode_reg <= 1'b0;
         seq_addr_reg <= 24'h000000;
      end else if (opcode_xfer) begin
         if (op_is(link.op, fms_pkg::OP_SEQ_PROG_A, fms_pkg::OP_SEQ_PROG_B)) begin
            if (!seq_mode_reg && link.has_addr) begin
               seq_mode_reg <= 1'b1;
               seq_addr_reg <= link.addr + fms_pkg::ADDR_STEP;
            end else if (seq_mode_reg) begin
               seq_addr_reg <= seq_addr_reg + fms_pkg::ADDR_STEP;
            end
         end else if (link.op == fms_pkg::OP_WR_DIS) begin
            seq_mode_reg <= 1'b0;
         end
      end
   end

   // continuous quad read tracking
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xip_reg <= 1'b0;
         xip_align_reg <= 1'b0;
      end else if (!xip_sel_reg || !quad_enable) begin
         xip_reg <= 1'b0;
      end else if (opcode_xfer) begin
         // opcode single line, rest on four
         xip_reg <= qread_op && link.quad_io;
         xip_align_reg <= link.op == fms_pkg::OP_QREAD_ALIGN;
      end
   end

   // array strobes and answers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_req <= 1'b0;
         rd_addr <= 24'h000000;
         pg_req <= 1'b0;
         pg_addr <= 24'h000000;
         pg_data <= 8'h00;
         term_req <= 1'b0;
         link.rsp_valid <= 1'b0;
         link.rsp_data <= 8'h00;
      end else begin
         rd_req <= 1'b0;
         pg_req <= 1'b0;
         term_req <= 1'b0;
         link.rsp_valid <= link.req;
         link.rsp_data <= 8'h00;
         if (opcode_xfer) begin
            if (qread_op && link.quad_io) begin
               rd_req <= 1'b1;
               rd_addr <= xip_addr;
            end else if (op_is(link.op, fms_pkg::OP_SEQ_PROG_A, fms_pkg::OP_SEQ_PROG_B) &&
               (seq_mode_reg || link.has_addr)) begin
               pg_req <= 1'b1;
               pg_addr <= seq_mode_reg ? seq_addr_reg : link.addr;
               pg_data <= link.data;
            end else if (link.op == fms_pkg::OP_TERM) begin
               term_req <= terminate_enable_reg;
            end else if (link.op == fms_pkg::OP_RD_MODE) begin
               link.rsp_data <= mode_byte;
            end else if (link.op == fms_pkg::OP_RD_LOCK) begin
               link.rsp_data <= lock_byte;
            end
         end else if (link.req && xip_reg && link.quad_io) begin
            rd_req <= 1'b1;
            rd_addr <= xip_addr;
         end
      end
   end

   // exported configuration
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dummy_clocks <= fms_pkg::DC_CLK_2;
         xip_active <= 1'b0;
      end else begin
         dummy_clocks <= dc_clocks(dc_reg);
         xip_active <= xip_reg;
      end
   end
endmodule

// ---- fms_pkg.sv ----
// shared constants for the flash mode/status register pair and its command link
package fms_pkg;
   // ==========================================================
   // link opcodes
   localparam logic [7:0] OP_SEQ_PROG_A = 8'had;  // sequential program, first form
   localparam logic [7:0] OP_SEQ_PROG_B = 8'haf;  // sequential program, second form
   localparam logic [7:0] OP_QREAD = 8'heb;       // quad continuous read
   localparam logic [7:0] OP_QREAD_ALIGN = 8'he7; // quad read, aligned address
   localparam logic [7:0] OP_SET_WRAP = 8'h77;    // set burst wrap
   localparam logic [7:0] OP_LOCK = 8'h6f;        // register lock
   localparam logic [7:0] LOCK_VER1 = 8'h4d;      // first verification byte
   localparam logic [7:0] LOCK_VER2 = 8'h67;      // second verification byte
   localparam logic [7:0] OP_SUSP_A = 8'h75;      // suspend
   localparam logic [7:0] OP_SUSP_B = 8'hb0;      // suspend, alternate
   localparam logic [7:0] OP_RES_A = 8'h7a;       // resume
   localparam logic [7:0] OP_RES_B = 8'hd0;       // resume, alternate
   localparam logic [7:0] OP_WR_DIS = 8'h04;      // write disable, leaves sequential mode
   localparam logic [7:0] OP_TERM = 8'hf0;        // terminate
   localparam logic [7:0] OP_RD_MODE = 8'h35;     // read mode/quad-read register
   localparam logic [7:0] OP_RD_LOCK = 8'h15;     // read lock/dummy/suspend register
   localparam logic [7:0] OP_WR_MODE = 8'h3e;     // write mode/quad-read register
   localparam logic [7:0] OP_WR_LOCK = 8'h1e;     // write lock/dummy/suspend register
   // ==========================================================
   // mode/quad-read register layout
   localparam int MODE_SEQ_BIT = 6;   // sequential_mode_flag
   localparam int MODE_XIP_BIT = 3;   // continuous_read_select
   localparam int MODE_WRAP_LO = 0;   // burst_wrap_mirror low bit
   localparam int WRAP_SRC_LO = 4;    // wrap_setting_bits low bit in data byte
   localparam logic [2:0] WRAP_RESET = 3'h1;
   // ==========================================================
   // lock/dummy/suspend register layout
   localparam int LK_LOCK_BIT = 7;    // register_lock_flag
   localparam int LK_DC_LO = 4;       // dummy_cycle_count low bit
   localparam int LK_ES_BIT = 3;      // erase_suspended_flag
   localparam int LK_PS_BIT = 2;      // program_suspended_flag
   localparam int LK_TERMINATE_ENABLE_BIT = 1;    // terminate_enable
   localparam int LK_DWA_BIT = 0;     // aligned_address_enable
   localparam logic [2:0] DC_RESET = 3'h0;
   // dummy code to clocks, mode cycles within
   localparam logic [2:0] DC_CODE_2 = 3'h0;
   localparam logic [2:0] DC_CODE_4 = 3'h1;
   localparam logic [2:0] DC_CODE_6 = 3'h2;
   localparam logic [2:0] DC_CODE_8 = 3'h5;
   localparam logic [2:0] DC_CODE_10 = 3'h4;
   localparam logic [3:0] DC_CLK_2 = 4'h2;
   localparam logic [3:0] DC_CLK_4 = 4'h4;
   localparam logic [3:0] DC_CLK_6 = 4'h6;
   localparam logic [3:0] DC_CLK_8 = 4'h8;
   localparam logic [3:0] DC_CLK_10 = 4'ha;
   localparam logic [1:0] ALIGN_ZERO = 2'h0;
   localparam logic [23:0] ADDR_STEP = 24'h1;
   // ==========================================================
   // host register map (byte addresses)
   localparam logic [7:0] HA_CMD = 8'h00;
   localparam logic [7:0] HA_ADDR = 8'h04;
   localparam logic [7:0] HA_DATA = 8'h08;
   localparam logic [7:0] HA_RESP = 8'h0c;
   localparam logic [7:0] HA_IRQ_STAT = 8'h10;
   localparam logic [7:0] HA_IRQ_MASK = 8'h14;
   localparam int CMD_HAS_OP_BIT = 8;
   localparam int CMD_HAS_ADDR_BIT = 9;
   localparam int RESP_BUSY_BIT = 8;
   localparam int IRQ_DONE_BIT = 0;
   // lock sequence tracker
   typedef enum logic [1:0] {
      LK_IDLE = 2'b00,
      LK_GOT_OP = 2'b01,
      LK_GOT_V1 = 2'b10
   } fms_lock_t;
endpackage

// ---- fms_link_if.sv ----
// command link between the flash controller and the flash register block
`timescale 1ns/1ps
interface fms_link_if;
   logic req;           // one-cycle transfer strobe from controller
   logic has_op;        // opcode phase present
   logic has_addr;      // address phase present
   logic quad_io;       // address and data on four lines, opcode on one
   logic [7:0] op;      // opcode byte
   logic [23:0] addr;   // address
   logic [7:0] data;    // write data or mode byte
   logic rsp_valid;     // one-cycle answer strobe from device
   logic [7:0] rsp_data; // read data answer
   modport ctrl (output req, has_op, has_addr, quad_io, op, addr, data,
      input rsp_valid, rsp_data);
   modport dev (input req, has_op, has_addr, quad_io, op, addr, data,
      output rsp_valid, rsp_data);
endinterface

// ---- fms_ctrl.sv ----
// controller end: software registers that launch transfers on the command link
`timescale 1ns/1ps
module fms_ctrl (
   input wire logic clk,           // system clock
   input wire logic rst_b,         // async reset, active low
   input wire logic [7:0] addr,    // register byte address
   input wire logic [31:0] wdata,  // write data
   input wire logic wr,            // write strobe
   input wire logic rd,            // read strobe
   output logic [31:0] rdata,      // read data, cycle after rd
   output logic irq,               // level interrupt
   fms_link_if.ctrl link           // command link to the flash
);
   // ==========================================================
   // registers
   logic [23:0] addr_reg;     // transfer address
   logic [7:0] data_reg;      // transfer data
   logic [7:0] resp_reg;      // last answer byte
   logic busy_reg;            // transfer outstanding
   logic [0:0] irq_stat_reg;  // sticky events
   logic [0:0] irq_mask_reg;  // event enables
   logic cmd_wr;              // write to command register
   logic [7:0] cmd_op;        // opcode being launched
   logic is_quad;             // transfer on four lines: quad read, set wrap or no opcode

   assign cmd_wr = wr && addr == fms_pkg::HA_CMD && !busy_reg;
   assign cmd_op = wdata[7:0];
   assign is_quad = cmd_op == fms_pkg::OP_QREAD || cmd_op == fms_pkg::OP_QREAD_ALIGN ||
      cmd_op == fms_pkg::OP_SET_WRAP || !wdata[fms_pkg::CMD_HAS_OP_BIT];

   // address and data setup
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_reg <= 24'h000000;
         data_reg <= 8'h00;
      end else if (wr && addr == fms_pkg::HA_ADDR) begin
         addr_reg <= wdata[23:0];
      end else if (wr && addr == fms_pkg::HA_DATA) begin
         data_reg <= wdata[7:0];
      end
   end

   // launch one transfer per command write accepted while not busy
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link.req <= 1'b0;
         link.has_op <= 1'b0;
         link.has_addr <= 1'b0;
         link.quad_io <= 1'b0;
         link.op <= 8'h00;
         link.addr <= 24'h000000;
         link.data <= 8'h00;
         busy_reg <= 1'b0;
      end else begin
         link.req <= cmd_wr;
         if (cmd_wr) begin
            link.has_op <= wdata[fms_pkg::CMD_HAS_OP_BIT];
            link.has_addr <= wdata[fms_pkg::CMD_HAS_ADDR_BIT];
            link.quad_io <= is_quad;
            link.op <= cmd_op;
            link.addr <= addr_reg;
            link.data <= data_reg;
            busy_reg <= 1'b1;
         end else if (link.rsp_valid) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // answer capture and interrupt status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         resp_reg <= 8'h00;
         irq_stat_reg <= 1'h0;
         irq_mask_reg <= 1'h0;
      end else begin
         if (link.rsp_valid) begin
            resp_reg <= link.rsp_data;
         end
         if (wr && addr == fms_pkg::HA_IRQ_MASK) begin
            irq_mask_reg <= wdata[fms_pkg::IRQ_DONE_BIT];
         end
         // set wins over write-one-to-clear
         if (link.rsp_valid) begin
            irq_stat_reg <= 1'h1;
         end else if (wr && addr == fms_pkg::HA_IRQ_STAT && wdata[fms_pkg::IRQ_DONE_BIT]) begin
            irq_stat_reg <= 1'h0;
         end
      end
   end

   // read port and interrupt output
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 32'h00000000;
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_reg & irq_mask_reg);
         rdata <= 32'h00000000;
         if (rd) begin
            if (addr == fms_pkg::HA_ADDR) begin
               rdata <= {8'h00, addr_reg};
            end else if (addr == fms_pkg::HA_DATA) begin
               rdata <= {24'h000000, data_reg};
            end else if (addr == fms_pkg::HA_RESP) begin
               rdata <= {23'h000000, busy_reg, resp_reg};
            end else if (addr == fms_pkg::HA_IRQ_STAT) begin
               rdata <= {31'h00000000, irq_stat_reg};
            end else if (addr == fms_pkg::HA_IRQ_MASK) begin
               rdata <= {31'h00000000, irq_mask_reg};
            end
         end
      end
   end
endmodule

// ---- fms_props.sv ----
// link checker for the register pair
`timescale 1ns/1ps
module fms_props (
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic req, // transfer strobe
   input wire logic has_op, // opcode present
   input wire logic has_addr, // address present
   input wire logic quad_io, // four-line phases
   input wire logic [7:0] op, // opcode
   input wire logic [23:0] addr, // address
   input wire logic [7:0] data, // write data
   input wire logic rsp_valid, // answer strobe
   input wire logic [7:0] rsp_data // answer byte
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // reference state
   logic [7:0] lop; // opcode of last transfer
   logic [2:0] wrap_m; // expected wrap field
   logic seq_m; // expected sequential flag
   logic lock_m; // expected lock flag
   logic [1:0] lk_st; // lock sequence progress
   // mirror flags from link traffic
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lop <= 8'h00;
         wrap_m <= fms_pkg::WRAP_RESET;
         seq_m <= 1'b0;
         lock_m <= 1'b0;
         lk_st <= 2'h0;
      end else if (req) begin
         lop <= has_op ? op : 8'h00;
         if (has_op && op == fms_pkg::OP_SET_WRAP) wrap_m <= data[6:4];
         if (has_op && has_addr && (op == fms_pkg::OP_SEQ_PROG_A || op == fms_pkg::OP_SEQ_PROG_B))
            seq_m <= 1'b1;
         if (has_op && op == fms_pkg::OP_WR_DIS) seq_m <= 1'b0;
         lk_st <= (has_op && op == fms_pkg::OP_LOCK) ? 2'h1 :
            (has_op && lk_st == 2'h1 && op == fms_pkg::LOCK_VER1) ? 2'h2 : 2'h0;
         if (has_op && lk_st == 2'h2 && op == fms_pkg::LOCK_VER2) lock_m <= 1'b1;
      end
   end
   // ==========================================================
   // assertions
   a_rsp_timing: assert property (req |=> rsp_valid) else $error("answer missing");
   a_rsp_cause: assert property (rsp_valid |-> $past(req)) else $error("answer without transfer");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("answer too long");
   a_quad_lines: assert property (
      req && has_op && (op == fms_pkg::OP_QREAD || op == fms_pkg::OP_QREAD_ALIGN) |-> quad_io)
      else $error("quad read not on four lines");
   a_seq_noaddr: assert property (
      req && seq_m && has_op && (op == fms_pkg::OP_SEQ_PROG_A || op == fms_pkg::OP_SEQ_PROG_B)
      |-> !has_addr) else $error("address sent in sequential mode");
   a_mode_view: assert property (rsp_valid && lop == fms_pkg::OP_RD_MODE |->
      rsp_data[6] == seq_m && rsp_data[5:4] == 2'h0 && rsp_data[2:0] == wrap_m)
      else $error("mode register view wrong");
   a_lock_view: assert property (
      rsp_valid && lop == fms_pkg::OP_RD_LOCK |-> rsp_data[7] == lock_m) else $error("lock flag wrong");
   a_rsp_idle: assert property (rsp_valid && lop != fms_pkg::OP_RD_MODE &&
      lop != fms_pkg::OP_RD_LOCK |-> rsp_data == 8'h00) else $error("answer byte not zero");
   // main scenarios
   c_locked: cover property (rsp_valid && lop == fms_pkg::OP_RD_LOCK && rsp_data[7]);
   c_seq: cover property (req && seq_m);
   c_xip: cover property (req && !has_op && quad_io);
endmodule

// ---- flash_mode_status_config_regs_tb.sv ----
// bench: controller and flash registers over the link
`timescale 1ns/1ps
module flash_mode_status_config_regs_tb;
   logic clk = 1'b0; // system clock
   logic rst_b = 1'b0; // reset, active low
   logic [7:0] addr = 8'h00; // register address
   logic [31:0] wdata = 32'h0; // write data
   logic wr = 1'b0; // write strobe
   logic rd = 1'b0; // read strobe
   logic rd_d = 1'b0; // read taken at last edge
   logic qe = 1'b0; // quad enable level
   logic er_act = 1'b0; // erase in progress
   logic pg_act = 1'b0; // program in progress
   logic [31:0] rdata; // read data
   logic irq, rd_req, pg_req, term_req, xip_active; // device pulses and levels
   logic [23:0] rd_addr, pg_addr, last_rd, a; // addresses, scratch
   logic [7:0] pg_data, d; // program data, scratch
   logic [31:0] last_pg; // last programmed data and address
   logic [3:0] dummy_clocks; // dummy clock count
   logic [2:0] w; // wrap setting sent
   integer seed = 32'ha4ca471a; // random seed
   integer failures = 0, check_count = 0, rd_cnt = 0, term_cnt = 0, n; // counters
   logic [31:0] expq[$]; // expected read data
   logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h4, 3'h3}; // dummy codes
   logic [3:0] clks[6] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'h2}; // expected clocks
   fms_link_if link ();
   fms_ctrl u_fms_ctrl (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .link(link));
   fms_dev u_fms_dev (.clk(clk), .rst_b(rst_b), .link(link), .quad_enable(qe),
      .erase_active(er_act), .program_active(pg_act), .rd_req(rd_req), .rd_addr(rd_addr),
      .pg_req(pg_req), .pg_addr(pg_addr), .pg_data(pg_data), .term_req(term_req),
      .dummy_clocks(dummy_clocks), .xip_active(xip_active));
   fms_props u_fms_props (.clk(clk), .rst_b(rst_b), .req(link.req), .has_op(link.has_op),
      .has_addr(link.has_addr), .quad_io(link.quad_io), .op(link.op), .addr(link.addr),
      .data(link.data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
   // ==========================================================
   // clock, closing and watchdog
   always #5 clk = ~clk;
   task automatic wrap_up();
      if (failures == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // about eighteen times the expected run
   initial begin
      #100000;
      failures++;
      wrap_up();
   end
   // ==========================================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bw(input logic [7:0] ad, input logic [31:0] dt);
      @(posedge clk);
      addr <= ad;
      wdata <= dt;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic br(input logic [7:0] ad, input logic [31:0] e);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      expq.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // one link transfer, answer latched on return
   task automatic cmd(input logic hop, input logic had, input logic [7:0] o,
      input logic [23:0] ad, input logic [7:0] dt);
      bw(fms_pkg::HA_ADDR, {8'h00, ad});
      bw(fms_pkg::HA_DATA, {24'h0, dt});
      bw(fms_pkg::HA_CMD, {22'h0, had, hop, o});
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic oc(input logic [7:0] o, input logic [7:0] dt);
      cmd(1, 0, o, 24'h0, dt);
   endtask
   task automatic reg_rd(input bit lk, input logic [7:0] e);
      oc(lk ? fms_pkg::OP_RD_LOCK : fms_pkg::OP_RD_MODE, 8'h00);
      br(fms_pkg::HA_RESP, {24'h0, e});
   endtask
   // ==========================================================
   // watcher: queued reads, device pulses
   always @(posedge clk) begin
      if (rd_d) chk("rdata", expq.pop_front(), rdata);
      rd_d <= rd;
      if (rd_req) rd_cnt++;
      if (rd_req) last_rd = rd_addr;
      if (pg_req) last_pg = {pg_data, pg_addr};
      if (term_req) term_cnt++;
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      bw(fms_pkg::HA_IRQ_MASK, 32'h1);
      reg_rd(0, 8'h01);
      chk("irq", 1, irq);
      bw(fms_pkg::HA_IRQ_STAT, 32'h1);
      bw(fms_pkg::HA_IRQ_MASK, 32'h0);
      reg_rd(1, 8'h00);
      chk("irq", 0, irq);
      d = $random(seed);
      w = d[6:4];
      cmd(1, 1, fms_pkg::OP_SET_WRAP, 24'h0, d);
      oc(fms_pkg::OP_WR_MODE, 8'hff);
      reg_rd(0, {4'h0, 1'b1, w});
      // quad off: opcode every read
      a = $random(seed);
      cmd(1, 1, fms_pkg::OP_QREAD, a, 8'h00);
      n = rd_cnt;
      cmd(0, 1, 8'h00, ~a, 8'h00);
      chk("xip_active", 0, xip_active);
      chk("rd_cnt", n, rd_cnt);
      qe <= 1'b1;
      cmd(1, 1, fms_pkg::OP_QREAD, a, 8'h00);
      chk("xip_active", 1, xip_active);
      cmd(0, 1, 8'h00, ~a, 8'h00);
      chk("rd_addr", {8'h0, ~a}, last_rd);
      chk("rd_cnt", n + 2, rd_cnt);
      qe <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("xip_active", 0, xip_active);
      for (int i = 0; i < 6; i++) begin
         oc(fms_pkg::OP_WR_LOCK, {1'b0, codes[i], 4'h0});
         chk("dummy_clocks", clks[i], dummy_clocks);
         reg_rd(1, {1'b0, codes[i], 4'h0});
      end
      n = term_cnt;
      oc(fms_pkg::OP_TERM, 8'h00);
      chk("term_cnt", n, term_cnt);
      oc(fms_pkg::OP_WR_LOCK, 8'h02);
      cmd(1, 1, fms_pkg::OP_SET_WRAP, 24'h0, d);
      reg_rd(1, 8'h02);
      oc(fms_pkg::OP_TERM, 8'h00);
      chk("term_cnt", n + 1, term_cnt);
      oc(fms_pkg::OP_WR_LOCK, 8'h01);
      qe <= 1'b1;
      cmd(1, 1, fms_pkg::OP_QREAD_ALIGN, a, 8'h00);
      chk("rd_addr", {a[23:2], 2'h0}, last_rd);
      cmd(1, 1, fms_pkg::OP_QREAD, a, 8'h00);
      chk("rd_addr", a, last_rd);
      cmd(1, 1, fms_pkg::OP_SEQ_PROG_A, a, d);
      chk("pg", {d, a}, last_pg);
      reg_rd(0, {4'h4, 1'b1, w});
      cmd(1, 0, fms_pkg::OP_SEQ_PROG_B, ~a, ~d);
      chk("pg", {~d, a + fms_pkg::ADDR_STEP}, last_pg);
      oc(fms_pkg::OP_WR_DIS, 8'h00);
      reg_rd(0, {4'h0, 1'b1, w});
      er_act <= 1'b1;
      oc(fms_pkg::OP_SUSP_A, 8'h00);
      reg_rd(1, 8'h09);
      oc(fms_pkg::OP_RES_A, 8'h00);
      er_act <= 1'b0;
      pg_act <= 1'b1;
      oc(fms_pkg::OP_SUSP_B, 8'h00);
      reg_rd(1, 8'h05);
      oc(fms_pkg::OP_RES_B, 8'h00);
      pg_act <= 1'b0;
      // broken lock sequence, then full
      oc(fms_pkg::OP_LOCK, 8'h00);
      oc(fms_pkg::LOCK_VER1, 8'h00);
      oc(fms_pkg::OP_WR_DIS, 8'h00);
      oc(fms_pkg::LOCK_VER2, 8'h00);
      reg_rd(1, 8'h01);
      oc(fms_pkg::OP_LOCK, 8'h00);
      oc(fms_pkg::LOCK_VER1, 8'h00);
      oc(fms_pkg::LOCK_VER2, 8'h00);
      oc(fms_pkg::OP_WR_LOCK, 8'h00);
      reg_rd(1, 8'h81);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      reg_rd(0, 8'h01);
      reg_rd(1, 8'h00);
      repeat (2) @(posedge clk);
      wrap_up();
   end
endmodule
